// ===== frm_pkg.sv
/*
 * Shared constants of the fault response manager: register offsets,
 * field positions, reset values and response codes.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package frm_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CLEAR = 8'h08;
	localparam logic [7:0] OFF_EFFECT = 8'h0C;

	// control register field positions
	localparam int CTRL_LSD_LSB = 0;
	localparam int CTRL_GOV_LSB = 4;
	localparam int CTRL_FRQ_LSB = 8;
	localparam int CTRL_INH_BIT = 12;
	localparam int CTRL_CALC_LSB = 16;

	// status and clear bit positions
	localparam int ST_LSD_LSB = 0;
	localparam int ST_GOV_LSB = 3;
	localparam int ST_OVF_BIT = 9;
	localparam int ST_UNF_BIT = 10;
	localparam int ST_INH_LSB = 11;
	localparam int ST_LINK_BIT = 14;
	localparam int ST_CALC_BIT = 15;
	localparam int ST_WIDTH = 16;

	// reset values of the response fields
	localparam logic [3:0] LSD_RESET = 4'h7;
	localparam logic [2:0] GOV_RESET = 3'h5;
	localparam logic [2:0] FRQ_RESET = 3'h0;
	localparam logic INH_RESET = 1'b0;
	localparam logic [2:0] CALC_RESET = 3'h1;

	// four-bit low-side drain codes
	localparam logic [3:0] LSD_OFF = 4'h0;
	localparam logic [3:0] LSD_PHASE = 4'h2;
	localparam logic [3:0] LSD_PHASE_H = 4'h3;
	localparam logic [3:0] LSD_ALL = 4'h4;
	localparam logic [3:0] LSD_ALL_H = 4'h5;
	localparam logic [3:0] LSD_MOTOR = 4'h6;
	localparam logic [3:0] LSD_MOTOR_H = 4'h7;
	localparam logic [3:0] LSD_CP = 4'h8;
	localparam logic [3:0] LSD_CP_H = 4'h9;

	// three-bit codes shared by gate, frequency and calc monitors
	localparam logic [2:0] R3_OFF = 3'h0;
	localparam logic [2:0] R3_ALL = 3'h2;
	localparam logic [2:0] R3_MOTOR = 3'h3;
	localparam logic [2:0] R3_CP = 3'h4;
	localparam logic [2:0] R3_CP_H = 3'h5;

	localparam int SYNC_WIDTH = 15;
endpackage

// ===== frm_sync.sv
/*
 * Three-stage synchroniser for asynchronous fault levels.
 * The output moves only once the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none
module frm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					s1_reg <= async_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						sync_out[i] <= s3_reg;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== frm_top.sv
/*
 * Fault response manager: sticky fault status, response decoding into
 * gate-off and charge-pump-off commands, and the active-low diag output.
 * Assumes asynchronous monitor levels on pins, link and calc errors from
 * logic on pclk, and an APB master on the register side.
 */
// Notes on behaviour
// - low-side drain code picks phase, all, motor or all-plus-pump off, held or not.
// - low-side drain fault sets per-phase sticky flag and pulls diag low.
// - gate overvoltage code picks disabled, continue, all, motor, pump off, held.
// - six gate overvoltage flags with own clears; disabled code keeps diag high.
// - frequency code as gate code, default disabled, over and under flags.
// - frequency fault during safety oscillator loss never pulls diag low.
// - phase-off drives both gates of phase low; inhibit mode picks status.
// - all-off drives all nine gate outputs low, relays included.
// - motor-off drives only the six bridge outputs low.
// - pump-off opens pump switch and stops pump driver.
// - retained flag stays set until host writes one to its clear bit.
// - clear ignored while fault still reported; host repeats it later.
// - flag without retention never sets; its status bit stays zero.
// - diag low while any retained flag set, bar frequency flags during oscillator loss; high after all cleared.
// - without retention diag stays high through the fault.
// - held responses and calc all or pump-off last while flag set; others end with the fault.
// - new response code takes effect only once monitor flags are clear.
`timescale 1ns/1ps
`default_nettype none
module frm_top
	import frm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] lowside_drain_fault,
	input wire logic [5:0] gate_overvoltage_fault,
	input wire logic over_frequency_fault,
	input wire logic under_frequency_fault,
	input wire logic safety_monitor_oscillator_lost,
	input wire logic [2:0] inhibit_input,
	input wire logic link_error,
	input wire logic calc_error,
	output logic [8:0] gate_off,
	output logic charge_pump_switch_off,
	output logic charge_pump_driver_stop,
	output logic diag_fault_n
);
	logic [SYNC_WIDTH-1:0] pins_s;
	logic [2:0] lsd_s;
	logic [5:0] gov_s;
	logic ovf_s;
	logic unf_s;
	logic osc_lost_s;
	logic [2:0] inh_s;

	frm_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({inhibit_input, safety_monitor_oscillator_lost,
			under_frequency_fault, over_frequency_fault,
			gate_overvoltage_fault, lowside_drain_fault}),
		.sync_out(pins_s)
	);
	assign lsd_s = pins_s[2:0];
	assign gov_s = pins_s[8:3];
	assign ovf_s = pins_s[9];
	assign unf_s = pins_s[10];
	assign osc_lost_s = pins_s[11];
	assign inh_s = pins_s[14:12];

	// requested and effective response fields
	logic [3:0] lowside_drain_fault_response_reg;
	logic [2:0] gate_overvoltage_response_reg;
	logic [2:0] frequency_fault_response_reg;
	logic inhibit_input_response_reg;
	logic [2:0] calc_check_response_reg;
	logic [3:0] eff_lsd_reg;
	logic [2:0] eff_gov_reg;
	logic [2:0] eff_frq_reg;
	logic eff_inh_reg;
	logic [2:0] eff_calc_reg;
	logic [ST_WIDTH-1:0] status_reg;

	// apb: setup captures data, access phase always answers next cycle
	logic wr_en;
	logic [ST_WIDTH-1:0] clr_req;
	logic addr_ok;
	assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
		(paddr == OFF_CLEAR) || (paddr == OFF_EFFECT);
	assign wr_en = psel && penable && pready && pwrite && addr_ok;
	assign clr_req = (wr_en && paddr == OFF_CLEAR) ?
		pwdata[ST_WIDTH-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					OFF_CTRL: prdata <= {13'h0000,
						calc_check_response_reg, 3'h0,
						inhibit_input_response_reg, 1'b0,
						frequency_fault_response_reg, 1'b0,
						gate_overvoltage_response_reg,
						lowside_drain_fault_response_reg};
					OFF_STATUS: prdata <= {16'h0000, status_reg};
					OFF_EFFECT: prdata <= {13'h0000, eff_calc_reg,
						3'h0, eff_inh_reg, 1'b0, eff_frq_reg, 1'b0,
						eff_gov_reg, eff_lsd_reg};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lowside_drain_fault_response_reg <= LSD_RESET;
			gate_overvoltage_response_reg <= GOV_RESET;
			frequency_fault_response_reg <= FRQ_RESET;
			inhibit_input_response_reg <= INH_RESET;
			calc_check_response_reg <= CALC_RESET;
		end else if (wr_en && paddr == OFF_CTRL) begin
			lowside_drain_fault_response_reg <=
				pwdata[CTRL_LSD_LSB +: 4];
			gate_overvoltage_response_reg <= pwdata[CTRL_GOV_LSB +: 3];
			frequency_fault_response_reg <= pwdata[CTRL_FRQ_LSB +: 3];
			inhibit_input_response_reg <= pwdata[CTRL_INH_BIT];
			calc_check_response_reg <= pwdata[CTRL_CALC_LSB +: 3];
		end
	end

	logic lsd_busy;
	logic gov_busy;
	logic frq_busy;
	logic inh_busy;
	assign lsd_busy = |status_reg[ST_LSD_LSB +: 3];
	assign gov_busy = |status_reg[ST_GOV_LSB +: 6];
	assign frq_busy = status_reg[ST_OVF_BIT] || status_reg[ST_UNF_BIT];
	assign inh_busy = |status_reg[ST_INH_LSB +: 3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_lsd_reg <= LSD_RESET;
			eff_gov_reg <= GOV_RESET;
			eff_frq_reg <= FRQ_RESET;
			eff_inh_reg <= INH_RESET;
			eff_calc_reg <= CALC_RESET;
		end else begin
			if (!lsd_busy) begin
				eff_lsd_reg <= lowside_drain_fault_response_reg;
			end
			if (!gov_busy) begin
				eff_gov_reg <= gate_overvoltage_response_reg;
			end
			if (!frq_busy) begin
				eff_frq_reg <= frequency_fault_response_reg;
			end
			if (!inh_busy) begin
				eff_inh_reg <= inhibit_input_response_reg;
			end
			if (!status_reg[ST_CALC_BIT]) begin
				eff_calc_reg <= calc_check_response_reg;
			end
		end
	end

	logic [ST_WIDTH-1:0] det;
	logic [ST_WIDTH-1:0] retain;
	assign det = {calc_error, link_error, inh_s, unf_s, ovf_s, gov_s, lsd_s};
	assign retain = {eff_calc_reg != R3_OFF, 1'b1, {3{eff_inh_reg}},
		{2{eff_frq_reg != R3_OFF}}, {6{eff_gov_reg != R3_OFF}},
		{3{eff_lsd_reg != LSD_OFF}}};

	genvar i;
	generate
		for (i = 0; i < ST_WIDTH; i++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status_reg[i] <= 1'b0;
				end else if (det[i] && retain[i]) begin
					status_reg[i] <= 1'b1;
				end else if (clr_req[i] && !det[i]) begin
					status_reg[i] <= 1'b0;
				end else if (!retain[i]) begin
					status_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// three-bit response decode: all, motor, pump
	function automatic logic [2:0] frm_dec3(input logic [2:0] code,
		input logic live, input logic held);
		logic [2:0] r;
		r = 3'b000;
		case (code)
			R3_ALL: r = {live, live, 1'b0};
			R3_MOTOR: r = {1'b0, live, 1'b0};
			R3_CP: r = {live, live, live};
			R3_CP_H: r = {held, held, held};
			default: r = 3'b000;
		endcase
		return r;
	endfunction

	logic [2:0] gov_act;
	logic [2:0] frq_act;
	logic [2:0] calc_act;
	logic [2:0] lsd_act;
	logic [2:0] phase_off;
	logic all_off;
	logic motor_off;
	logic pump_off;
	logic lsd_live;

	assign gov_act = frm_dec3(eff_gov_reg, |gov_s, gov_busy);
	// frequency decode, applied even without safety oscillator
	assign frq_act = frm_dec3(eff_frq_reg, ovf_s || unf_s, frq_busy);
	assign lsd_live = |lsd_s;

	always_comb begin
		lsd_act = 3'b000;
		phase_off = 3'b000;
		case (eff_lsd_reg)
			LSD_PHASE: phase_off = lsd_s;
			LSD_PHASE_H: phase_off = status_reg[ST_LSD_LSB +: 3];
			LSD_ALL: lsd_act = {lsd_live, lsd_live, 1'b0};
			LSD_ALL_H: lsd_act = {lsd_busy, lsd_busy, 1'b0};
			LSD_MOTOR: lsd_act = {1'b0, lsd_live, 1'b0};
			LSD_MOTOR_H: lsd_act = {1'b0, lsd_busy, 1'b0};
			LSD_CP: lsd_act = {3{lsd_live}};
			LSD_CP_H: lsd_act = {3{lsd_busy}};
			default: lsd_act = 3'b000;
		endcase
		phase_off = phase_off | inh_s;
	end

	always_comb begin
		case (eff_calc_reg)
			R3_ALL: calc_act = {{2{status_reg[ST_CALC_BIT]}}, 1'b0};
			R3_MOTOR: calc_act = {1'b0, calc_error, 1'b0};
			R3_CP: calc_act = {3{status_reg[ST_CALC_BIT]}};
			default: calc_act = 3'b000;
		endcase
	end

	// link error has no action term
	assign all_off = gov_act[2] | frq_act[2] | calc_act[2] | lsd_act[2];
	assign motor_off = gov_act[1] | frq_act[1] | calc_act[1] | lsd_act[1];
	assign pump_off = gov_act[0] | frq_act[0] | calc_act[0] | lsd_act[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_off <= 9'h000;
		end else begin
			gate_off[8:6] <= {3{all_off}};
			gate_off[5:0] <= {6{motor_off | all_off}} |
				{{2{phase_off[2]}}, {2{phase_off[1]}}, {2{phase_off[0]}}};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_pump_switch_off <= 1'b0;
			charge_pump_driver_stop <= 1'b0;
		end else begin
			charge_pump_switch_off <= pump_off;
			charge_pump_driver_stop <= pump_off;
		end
	end

	// frequency flags masked while oscillator lost
	logic diag_src;
	assign diag_src = (|status_reg[8:0]) | (|status_reg[15:11]) |
		((status_reg[ST_OVF_BIT] | status_reg[ST_UNF_BIT]) & !osc_lost_s);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_fault_n <= 1'b1;
		end else begin
			diag_fault_n <= !diag_src;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_diag_low_flags: assert property (|status_reg[8:0] |=> !diag_fault_n)
		else $error("diag high while flag set");
	a_diag_osc_lost: assert property ((osc_lost_s && status_reg[8:0] == 9'h000
		&& status_reg[15:11] == 5'h00) |=> diag_fault_n)
		else $error("diag low from frequency flag with oscillator lost");
	a_clear_blocked: assert property ((clr_req[ST_LINK_BIT] && link_error)
		|=> status_reg[ST_LINK_BIT])
		else $error("link flag cleared while error present");
	a_clear_done: assert property ((clr_req[ST_LINK_BIT] && !link_error)
		|=> !status_reg[ST_LINK_BIT])
		else $error("link flag not cleared");
	a_gov_disabled: assert property (eff_gov_reg == R3_OFF |=>
		status_reg[8:3] == 6'h00)
		else $error("gate flag set while disabled");
	a_held_shutdown: assert property ((eff_gov_reg == R3_CP_H && gov_busy)
		|=> gate_off == 9'h1FF && charge_pump_switch_off)
		else $error("held shutdown missing");
	a_cfg_frozen: assert property (lsd_busy |=> $stable(eff_lsd_reg))
		else $error("low-side code changed while flagged");
	a_inhibit_phase: assert property (inh_s[0] |=> gate_off[1:0] == 2'b11)
		else $error("inhibited phase not off");
	a_lsd_phase: assert property ((eff_lsd_reg == LSD_PHASE && lsd_s[1])
		|=> gate_off[3:2] == 2'b11)
		else $error("faulty phase not off");
	a_calc_motor: assert property ((eff_calc_reg == R3_MOTOR && calc_error
		&& !all_off) |=> gate_off[5:0] == 6'h3F && gate_off[8:6] == 3'h0)
		else $error("motor-off wrong");

	c_held_then_clear: cover property (gov_busy ##[1:20] !gov_busy);
	c_osc_lost_fault: cover property (osc_lost_s && frq_busy);
	c_blocked_clear: cover property (clr_req[ST_LSD_LSB] && lsd_s[0]);
	c_link_error: cover property (link_error ##1 !diag_fault_n);
endmodule
`default_nettype wire

// ===== frm_host_model.sv
/*
 Host side of the fault manager: an APB master offering one transfer task.
 Assumes a single pclk domain and a slave that raises pready to finish.
*/
`timescale 1ns/1ps
`default_nettype none
module frm_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int stall_count = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// request held until the edge that sees pready high, or for at most 20 edges
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rdata, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			stall_count++;
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
 Self-checking bench for the fault response manager: drives fault pins,
 reaches registers through the host model, compares with a table model.
 Assumes every APB transfer is answered within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import frm_pkg::*;
	typedef struct {int kind; int idx; logic [31:0] ctrl; logic [11:0] on;
		logic [11:0] off; logic [31:0] st;} frm_case_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf, unf;
	logic osc, link, calc, cpsw, cpdrv, diag_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [2:0] lsd, inh;
	logic [5:0] gov;
	logic [8:0] gate_off;
	logic e;
	wire [11:0] outs;
	int fail_count = 0;
	int samples_checked = 0;
	int lsd_codes[8] = '{7, 2, 3, 4, 5, 6, 8, 9};
	frm_case_s q[$];
	assign outs = {cpsw, cpdrv, gate_off, diag_n};
	frm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lowside_drain_fault(lsd), .gate_overvoltage_fault(gov),
		.over_frequency_fault(ovf), .under_frequency_fault(unf),
		.safety_monitor_oscillator_lost(osc), .inhibit_input(inh),
		.link_error(link), .calc_error(calc), .gate_off(gate_off),
		.charge_pump_switch_off(cpsw), .charge_pump_driver_stop(cpdrv),
		.diag_fault_n(diag_n));
	frm_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		check("bus stalls", i_host.stall_count, 0);
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_host.xfer(1'b1, a, v, d, e);
		if (i_host.stall_count != 0)
			tally_and_finish();
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] v,
		input string nm);
		i_host.xfer(1'b0, a, 32'h0, d, e);
		if (i_host.stall_count != 0)
			tally_and_finish();
		check(nm, d, v);
	endtask
	// fault pins move only after an edge, by non-blocking assignment
	task automatic drive(input int k, input int i, input logic v);
		@(posedge pclk);
		case (k)
			0: lsd[i] <= v;
			1: gov[i] <= v;
			2: ovf <= v;
			3: unf <= v;
			4: inh[i] <= v;
			5: link <= v;
			default: calc <= v;
		endcase
		repeat (6) @(posedge pclk);
	endtask
	task automatic wait_out(input logic [11:0] x, input string nm);
		int i;
		for (i = 0; i < 12; i++) begin
			@(posedge pclk);
			#1;
			if (outs === x)
				break;
		end
		check(nm, {20'h0, outs}, {20'h0, x});
		if (i == 12)
			tally_and_finish();
	endtask
	function automatic logic [11:0] lsd_on(input int c, input int p);
		logic [8:0] g;
		g = (c < 4) ? 9'h3 << (2 * p) : (c == 6 || c == 7) ? 9'h3F : 9'h1FF;
		return {(c > 7), (c > 7), g, 1'b0};
	endfunction
	task automatic run(input frm_case_s c);
		wr(OFF_CTRL, c.ctrl);
		drive(c.kind, c.idx, 1'b1);
		wait_out(c.on, "outputs on fault");
		rd_chk(OFF_STATUS, c.st, "status on fault");
		wr(OFF_CLEAR, c.st);
		rd_chk(OFF_STATUS, c.st, "status after early clear");
		drive(c.kind, c.idx, 1'b0);
		wait_out(c.off, "outputs after fault");
		rd_chk(OFF_STATUS, c.st, "status retained");
		wr(OFF_CLEAR, c.st);
		wait_out(12'h001, "outputs after clear");
		rd_chk(OFF_STATUS, 32'h0, "status cleared");
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		int i, c, p, g;
		{lsd, gov, inh, ovf, unf, osc, link, calc} = '0;
		presetn = 1'b0;
		void'($urandom(15));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFF_CTRL, 32'h0001_0057, "ctrl reset");
		rd_chk(OFF_EFFECT, 32'h0001_0057, "effect reset");
		rd_chk(OFF_STATUS, 32'h0, "status reset");
		i_host.xfer(1'b0, 8'h10, 32'h0, d, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", d, 32'h0);
		wait_out(12'h001, "idle outputs");
		for (i = 0; i < 8; i++) begin
			p = $urandom % 3;
			c = lsd_codes[i];
			q.push_back('{0, p, 32'h0001_0000 | c, lsd_on(c, p),
				c[0] ? lsd_on(c, p) : 12'h000, 1 << p});
		end
		g = $urandom % 6;
		p = $urandom % 3;
		q.push_back('{1, g, 32'h0001_0000, 12'h001, 12'h001, 0});
		q.push_back('{1, g, 32'h0001_0010, 12'h000, 12'h000, 8 << g});
		q.push_back('{1, g, 32'h0001_0030, 12'h07E, 12'h000, 8 << g});
		q.push_back('{1, g, 32'h0001_0050, 12'hFFE, 12'hFFE, 8 << g});
		q.push_back('{1, g, 32'h0001_0020, 12'h3FE, 12'h000, 8 << g});
		q.push_back('{2, 0, 32'h0001_0500, 12'hFFE, 12'hFFE, 32'h200});
		q.push_back('{0, p, 32'h0001_0001, 12'h000, 12'h000, 1 << p});
		q.push_back('{6, 0, 32'h0004_0000, 12'hFFE, 12'hFFE, 32'h8000});
		q.push_back('{3, 0, 32'h0001_0400, 12'hFFE, 12'h000, 32'h400});
		q.push_back('{4, p, 32'h0001_0000, (12'h6 << 2 * p) | 12'h001,
			12'h001, 0});
		q.push_back('{4, p, 32'h0001_1000, 12'h6 << 2 * p, 12'h000,
			32'h800 << p});
		q.push_back('{5, 0, 32'h0001_0057, 12'h000, 12'h000, 32'h4000});
		q.push_back('{6, 0, 32'h0002_0000, 12'h3FE, 12'h3FE, 32'h8000});
		q.push_back('{6, 0, 32'h0003_0000, 12'h07E, 12'h000, 32'h8000});
		foreach (q[k])
			run(q[k]);
		osc <= 1'b1;
		run('{2, 0, 32'h0001_0200, 12'h3FF, 12'h001, 32'h200});
		osc <= 1'b0;
		wr(OFF_CTRL, 32'h0001_0006);
		drive(0, 0, 1'b1);
		wait_out(12'h07E, "motor off before change");
		wr(OFF_CTRL, 32'h0001_0004);
		rd_chk(OFF_EFFECT, 32'h0001_0006, "effect kept while flagged");
		rd_chk(OFF_CTRL, 32'h0001_0004, "ctrl stored");
		drive(0, 0, 1'b0);
		wr(OFF_CLEAR, 32'h1);
		wait_out(12'h001, "idle after change");
		rd_chk(OFF_EFFECT, 32'h0001_0004, "effect after clear");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFF_CTRL, 32'h0001_0057, "ctrl after reset");
		wait_out(12'h001, "idle after reset");
		tally_and_finish();
	end
endmodule
`default_nettype wire
